// ### verilog/dtp_pkg.sv
// Package: constants and types shared by the debug trace port design
package dtp_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DTP_IR_W = 5;
  localparam int unsigned DTP_DR_W = 32;
  localparam int unsigned DTP_STAT_W = 9;
  localparam int unsigned DTP_TPC_W = 3;
  localparam int unsigned DTP_PC_W = 4;

  // ----------------------------------------------------------------
  // Counts, reset values, instruction and status codes
  // ----------------------------------------------------------------
  localparam logic [1:0] DTP_DIV_LAST = 2'h2;
  localparam logic [DTP_IR_W-1:0] DTP_IR_RST = 5'h01;
  localparam logic [DTP_IR_W-1:0] DTP_IR_RTM = 5'h10;
  localparam logic [DTP_DR_W-1:0] DTP_DR_RST = 32'h00000000;
  localparam logic [2:0] DTP_ST_IDLE = 3'h0;
  localparam logic [2:0] DTP_ST_SHIFT = 3'h1;
  localparam logic [2:0] DTP_ST_RTM = 3'h2;

  // Scan controller states, one-hot
  typedef enum logic [3:0] {
    DTP_IDLE = 4'h1,
    DTP_SEL = 4'h2,
    DTP_SHDR = 4'h4,
    DTP_SHIR = 4'h8
  } dtp_scan_t;
endpackage

// ### verilog/dtp_sync.sv
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/10ps
module dtp_sync
  import dtp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Pin and clean level
  input wire logic pin_in,
  output logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second, guarding against metastability
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
      begin
        level_out <= s3_r;
      end
    end
  end
endmodule

// ### verilog/dtp_buf2.sv
// Two-entry valid/ready buffer for trace words
`timescale 1ns/10ps
module dtp_buf2
  import dtp_pkg::*;
#(
  parameter int unsigned WIDTH = 12
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rp_r];

  // Storage, no reset needed on data
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= ~wp_r;
      end
      if (pop)
      begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### verilog/dtp_port.sv
// Debug trace port: serial scan path, trace outputs and debug clock
//
// Contract
// - Serial data in and command select are sampled on each rising serial clock edge.
// - In run-time mode serial input bits shift into the selected data or instruction register.
// - In real-time mode serial input acts as a debug interrupt that returns to run-time mode.
// - In run-time mode the serial output carries bits shifted out of the selected register.
// - Non-sequential PC bits go out on the trace PC pins; in real-time mode the serial output carries bit 0.
// - The device makes the trace clock and times all scan and trace outputs against it.
// - The trace clock is the operating clock divided by three.
// - A nine-bit trace status output gives PC trace status and the scan mode.
// - Asserting the active-low test reset returns the debug support unit to its initial state.
`timescale 1ns/10ps
module dtp_port
  import dtp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Probe pins
  input wire logic debug_serial_clock,
  input wire logic debug_serial_in,
  input wire logic debug_command_select,
  input wire logic test_resetn,
  output logic debug_serial_out,
  output logic trace_clock_out,
  output logic [DTP_STAT_W-1:0] trace_status_out,
  output logic [DTP_TPC_W-1:0] trace_pc_out,
  // Core trace feed
  input wire logic trace_valid,
  output logic trace_ready,
  input wire logic [DTP_PC_W-1:0] trace_pc,
  input wire logic [DTP_STAT_W-1:0] trace_status,
  // Core side
  output logic realtime_mode,
  output logic [DTP_DR_W-1:0] scan_data
);
  logic tck_s;
  logic tdi_s;
  logic tms_s;
  logic trst_s;
  logic tck_d_r;
  logic tck_rise;
  logic tdi_d_r;
  logic tdi_rise;
  logic trst_n;
  logic [1:0] div_r;
  logic trace_clock_out_r;
  logic trace_clock_out_rise;
  dtp_scan_t scan_r;
  dtp_scan_t scan_nxt;
  logic [DTP_IR_W-1:0] ir_r;
  logic [DTP_IR_W-1:0] ir_sh_r;
  logic [DTP_DR_W-1:0] dr_r;
  logic rtm_r;
  logic tdo_r;
  logic buf_valid;
  logic buf_ready;
  logic [DTP_PC_W+DTP_STAT_W-1:0] buf_data;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  dtp_sync u_sync_tck (.ref_clk(ref_clk), .resetn(resetn), .pin_in(debug_serial_clock),
    .level_out(tck_s));
  dtp_sync u_sync_tdi (.ref_clk(ref_clk), .resetn(resetn), .pin_in(debug_serial_in),
    .level_out(tdi_s));
  dtp_sync u_sync_tms (.ref_clk(ref_clk), .resetn(resetn), .pin_in(debug_command_select),
    .level_out(tms_s));
  // Test reset idles high; its synchroniser resets low, so hold unit reset until it settles
  dtp_sync u_sync_trst (.ref_clk(ref_clk), .resetn(resetn), .pin_in(test_resetn),
    .level_out(trst_s));

  assign trst_n = trst_s;

  // Edge detect on the cleaned serial clock and serial input, both idle low
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tck_d_r <= 1'b0;
      tdi_d_r <= 1'b0;
    end
    else
    begin
      tck_d_r <= tck_s;
      tdi_d_r <= tdi_s;
    end
  end

  assign tck_rise = tck_s && !tck_d_r;
  // The real-time instruction ends on a high bit, so only a fresh rise is an interrupt
  assign tdi_rise = tdi_s && !tdi_d_r;

  // ----------------------------------------------------------------
  // Trace clock divider
  // ----------------------------------------------------------------
  // Divide by three: high for one of three cycles, outputs change on its rise
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_r <= 2'h0;
      trace_clock_out_r <= 1'b0;
    end
    else
    begin
      div_r <= (div_r == DTP_DIV_LAST) ? 2'h0 : div_r + 2'h1;
      trace_clock_out_r <= (div_r == DTP_DIV_LAST);
    end
  end

  assign trace_clock_out = trace_clock_out_r;
  assign trace_clock_out_rise = (div_r == DTP_DIV_LAST);

  // ----------------------------------------------------------------
  // Scan controller
  // ----------------------------------------------------------------
  // Command select high picks the instruction path, low the data path
  always_comb
  begin
    scan_nxt = scan_r;
    unique case (scan_r)
      DTP_IDLE:
      begin
        if (tck_rise && !rtm_r)
        begin
          scan_nxt = DTP_SEL;
        end
      end
      DTP_SEL:
      begin
        if (tck_rise)
        begin
          scan_nxt = tms_s ? DTP_SHIR : DTP_SHDR;
        end
      end
      DTP_SHDR, DTP_SHIR:
      begin
        if (tck_rise && tms_s)
        begin
          scan_nxt = DTP_IDLE;
        end
      end
      default:
      begin
        scan_nxt = DTP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      scan_r <= DTP_IDLE;
    end
    else if (!trst_n)
    begin
      scan_r <= DTP_IDLE;
    end
    else
    begin
      scan_r <= scan_nxt;
    end
  end

  // Shift registers; the instruction takes effect when the shift ends
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ir_r <= DTP_IR_RST;
      ir_sh_r <= DTP_IR_RST;
      dr_r <= DTP_DR_RST;
    end
    else if (!trst_n)
    begin
      ir_r <= DTP_IR_RST;
      ir_sh_r <= DTP_IR_RST;
      dr_r <= DTP_DR_RST;
    end
    else if (tck_rise && !rtm_r)
    begin
      if (scan_r == DTP_SHIR)
      begin
        ir_sh_r <= {tdi_s, ir_sh_r[DTP_IR_W-1:1]};
        if (tms_s)
        begin
          ir_r <= {tdi_s, ir_sh_r[DTP_IR_W-1:1]};
        end
      end
      else if (scan_r == DTP_SHDR)
      begin
        dr_r <= {tdi_s, dr_r[DTP_DR_W-1:1]};
      end
    end
  end

  assign scan_data = dr_r;

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  // Loading the real-time instruction enters real-time; a rising serial input leaves it
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rtm_r <= 1'b0;
    end
    else if (!trst_n)
    begin
      rtm_r <= 1'b0;
    end
    else if (rtm_r && tdi_rise)
    begin
      rtm_r <= 1'b0;
    end
    else if (scan_r == DTP_SHIR && scan_nxt == DTP_IDLE &&
             {tdi_s, ir_sh_r[DTP_IR_W-1:1]} == DTP_IR_RTM)
    begin
      rtm_r <= 1'b1;
    end
  end

  assign realtime_mode = rtm_r;

  // ----------------------------------------------------------------
  // Trace path
  // ----------------------------------------------------------------
  // Buffer lets the core run ahead by two words while the divider paces output
  dtp_buf2 #(.WIDTH(DTP_PC_W + DTP_STAT_W)) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(trace_valid),
    .in_ready(trace_ready),
    .in_data({trace_pc, trace_status}),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  assign buf_ready = trace_clock_out_rise;

  // Status reports scan mode when idle of trace words
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trace_status_out <= '0;
      trace_pc_out <= '0;
      tdo_r <= 1'b0;
    end
    else if (trace_clock_out_rise)
    begin
      if (buf_valid)
      begin
        trace_status_out <= buf_data[DTP_STAT_W-1:0];
        trace_pc_out <= buf_data[DTP_PC_W+DTP_STAT_W-1:DTP_STAT_W+1];
      end
      else
      begin
        trace_status_out <= {6'h00, rtm_r ? DTP_ST_RTM :
          (scan_r == DTP_IDLE ? DTP_ST_IDLE : DTP_ST_SHIFT)};
      end
      if (rtm_r)
      begin
        tdo_r <= buf_valid ? buf_data[DTP_STAT_W] : 1'b0;
      end
      else
      begin
        tdo_r <= (scan_r == DTP_SHIR) ? ir_sh_r[0] : dr_r[0];
      end
    end
  end

  assign debug_serial_out = tdo_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ir_done;
    scan_r == DTP_SHIR && scan_nxt == DTP_IDLE;
  endsequence

  a_div_period: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(trace_clock_out_r) |=> !trace_clock_out_r ##1 !trace_clock_out_r ##1 trace_clock_out_r)
    else $error("trace clock not divide by three");

  a_trace_clock_out_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    trace_clock_out_r |=> !trace_clock_out_r)
    else $error("trace clock high too long");

  a_out_stable: assert property (@(posedge ref_clk) disable iff (!resetn)
    !trace_clock_out_rise |=> $stable(tdo_r) && $stable(trace_pc_out))
    else $error("outputs changed off trace clock");

  a_rtm_exit: assert property (@(posedge ref_clk) disable iff (!resetn)
    rtm_r && tdi_rise && trst_n |=> !rtm_r)
    else $error("debug interrupt ignored");

  a_trst_init: assert property (@(posedge ref_clk) disable iff (!resetn)
    !trst_n |=> scan_r == DTP_IDLE && !rtm_r && ir_r == DTP_IR_RST)
    else $error("test reset did not initialise");

  a_dr_shift: assert property (@(posedge ref_clk) disable iff (!resetn)
    trst_n && tck_rise && !rtm_r && scan_r == DTP_SHDR |=> dr_r[DTP_DR_W-1] == $past(tdi_s))
    else $error("data bit not shifted in");

  a_sel_path: assert property (@(posedge ref_clk) disable iff (!resetn)
    trst_n && scan_r == DTP_SEL && tck_rise && tms_s |=> scan_r == DTP_SHIR)
    else $error("command select not honoured");

  a_ir_load: assert property (@(posedge ref_clk) disable iff (!resetn)
    (trst_n && !rtm_r) ##0 s_ir_done |=>
      ir_r == {$past(tdi_s), $past(ir_sh_r[DTP_IR_W-1:1])})
    else $error("instruction not loaded");

  a_tdo_run: assert property (@(posedge ref_clk) disable iff (!resetn)
    trace_clock_out_rise && !rtm_r && scan_r == DTP_SHDR |=> tdo_r == $past(dr_r[0]))
    else $error("serial out wrong in run-time mode");

  a_idle_status: assert property (@(posedge ref_clk) disable iff (!resetn)
    trace_clock_out_rise && !buf_valid && rtm_r |=> trace_status_out == {6'h00, DTP_ST_RTM})
    else $error("status missing real-time mode");
endmodule

// ### tb/dtp_probe.sv
// Probe model: drives the serial scan pins and the test reset of the debug port
`timescale 1ns/10ps
module dtp_probe
(
  // Clock
  input wire logic ref_clk,
  // Probe pins
  output logic debug_serial_clock,
  output logic debug_serial_in,
  output logic debug_command_select,
  output logic test_resetn,
  input wire logic debug_serial_out
);
  // Half period in ref_clk cycles, kept well above the minimum serial period
  localparam int HALF = 6;
  logic [31:0] cap_r;

  // Serial clock stands low outside frames; test reset starts asserted
  initial
  begin
    debug_serial_clock = 1'b0;
    debug_serial_in = 1'b0;
    debug_command_select = 1'b0;
    test_resetn = 1'b0;
    cap_r = 32'h00000000;
  end

  // Pins only change on the falling edge of ref_clk
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One serial period: bits settle in the low half, output captured just before the rise
  task automatic bit_cycle(input logic tdi, input logic tms);
    debug_serial_in = tdi;
    debug_command_select = tms;
    wait_n(HALF);
    cap_r = {debug_serial_out, cap_r[31:1]};
    debug_serial_clock = 1'b1;
    wait_n(HALF);
    debug_serial_clock = 1'b0;
  endtask

  // Full frame: leave idle, pick IR or DR, shift n bits LSB first, last bit ends the frame
  task automatic scan(input logic is_ir, input logic [31:0] val, input int n);
    int i;
    bit_cycle(1'b0, 1'b0);
    bit_cycle(1'b0, is_ir);
    for (i = 0; i < n; i++)
      bit_cycle(val[i], i == n - 1);
    cap_r = cap_r >> (32 - n);
    // Select is not sampled between frames, so it shows the opposite of its last level
    debug_command_select = ~debug_command_select;
    // Data stays low so that it never reads as a debug interrupt
    debug_serial_in = 1'b0;
    wait_n(12);
  endtask

  // Debug interrupt: level high on the data input for a few cycles
  task automatic irq();
    debug_serial_in = 1'b1;
    wait_n(10);
    debug_serial_in = 1'b0;
    wait_n(12);
  endtask

  // Test reset pulse, long enough to cross the synchroniser
  task automatic treset();
    test_resetn = 1'b0;
    wait_n(8);
    test_resetn = 1'b1;
    wait_n(8);
  endtask
endmodule

// ### tb/tb_top.sv
// Self-checking testbench for the debug trace port
`timescale 1ns/10ps
module tb_top;
  import dtp_pkg::*;
  logic ref_clk;
  logic resetn;
  logic trace_valid;
  logic [DTP_PC_W-1:0] trace_pc;
  logic [DTP_STAT_W-1:0] trace_status;
  logic sclk, sin, ssel, trstn, sout, tclk, trace_ready, realtime_mode;
  logic [DTP_STAT_W-1:0] stat_out;
  logic [DTP_TPC_W-1:0] tpc_out;
  logic [DTP_DR_W-1:0] scan_data;
  logic [12:0] exp_q[$];
  logic [12:0] seen_q[$];
  logic [12:0] last_r;
  logic [31:0] v1, v2;
  int n_mismatch;
  int checked;
  int i, highs, dbl;
  logic tprev;

  dtp_port dut_u (.ref_clk(ref_clk), .resetn(resetn), .debug_serial_clock(sclk),
    .debug_serial_in(sin), .debug_command_select(ssel), .test_resetn(trstn),
    .debug_serial_out(sout), .trace_clock_out(tclk), .trace_status_out(stat_out),
    .trace_pc_out(tpc_out), .trace_valid(trace_valid), .trace_ready(trace_ready),
    .trace_pc(trace_pc), .trace_status(trace_status), .realtime_mode(realtime_mode),
    .scan_data(scan_data));

  dtp_probe probe_u (.ref_clk(ref_clk), .debug_serial_clock(sclk), .debug_serial_in(sin),
    .debug_command_select(ssel), .test_resetn(trstn), .debug_serial_out(sout));

  // 125 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Trace words carry status bit 8 set, which no mode code has, so changes mark emissions
  always @(negedge ref_clk)
  begin
    if (stat_out[8] === 1'b1 && {stat_out, tpc_out} !== last_r[12:1])
      seen_q.push_back({stat_out, tpc_out, sout});
    last_r = {stat_out, tpc_out, sout};
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Random trace word {status, pc}, never equal to the previous one on the pins
  function automatic logic [12:0] gen(input logic [12:0] prev);
    logic [12:0] w;
    w = 13'($urandom);
    w[12] = 1'b1;
    if (w[12:1] == prev[12:1])
      w[1] = ~w[1];
    return w;
  endfunction

  // Pins expected for a word: status, pc bits 3:1, and bit 0 on serial out in real time
  function automatic logic [12:0] pins_of(input logic [12:0] w, input logic rt, input logic s);
    return {w[12:4], w[3:1], rt ? w[0] : s};
  endfunction

  // Back-to-back burst held valid; the two-entry buffer must refuse at some point
  task automatic burst(input logic rt);
    int k, full;
    logic [12:0] w;
    w = 13'h0000;
    full = 0;
    for (int n = 0; n < 5; n++)
    begin
      w = gen(w);
      trace_valid = 1'b1;
      trace_status = w[12:4];
      trace_pc = w[3:0];
      k = 0;
      while (trace_ready !== 1'b1 && k < 50)
      begin
        full = 1;
        @(negedge ref_clk);
        k++;
      end
      @(negedge ref_clk);
      exp_q.push_back(w);
    end
    trace_valid = 1'b0;
    repeat (30) @(negedge ref_clk);
    chk(full, 1);
    chk(seen_q.size(), exp_q.size());
    while (exp_q.size() > 0 && seen_q.size() > 0)
    begin
      w = exp_q.pop_front();
      chk(seen_q[0], pins_of(w, rt, seen_q[0][0]));
      void'(seen_q.pop_front());
    end
    exp_q.delete();
    seen_q.delete();
  endtask

  // Watchdog, far beyond the expected run of about 1800 cycles
  initial
  begin
    #400000;
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    resetn = 1'b0;
    trace_valid = 1'b0;
    trace_pc = 4'h0;
    trace_status = 9'h000;
    last_r = 13'h0000;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(4785));
    repeat (4) @(negedge ref_clk);
    chk({sout, tclk, tpc_out, realtime_mode, stat_out}, 32'h0);
    resetn = 1'b1;
    probe_u.treset();
    chk({realtime_mode, stat_out}, 32'h0);
    chk(scan_data, 32'h0);
    $display("test reset done");
    // Trace clock: high one cycle in three
    highs = 0;
    dbl = 0;
    tprev = 1'b0;
    for (i = 0; i < 30; i++)
    begin
      @(negedge ref_clk);
      highs += (tclk === 1'b1);
      dbl += (tclk === 1'b1 && tprev === 1'b1);
      tprev = tclk;
    end
    chk(highs, 10);
    chk(dbl, 0);
    $display("test divider done");
    probe_u.scan(1'b1, 32'h01, 5);
    chk(probe_u.cap_r, 32'h01);
    v1 = $urandom;
    v2 = $urandom;
    fork
      probe_u.scan(1'b0, v1, 32);
      begin
        repeat (60) @(negedge ref_clk);
        chk(stat_out, 32'h1);
      end
    join
    chk(scan_data, v1);
    probe_u.scan(1'b0, v2, 32);
    chk(probe_u.cap_r, v1);
    chk(scan_data, v2);
    $display("test scan done");
    burst(1'b0);
    $display("test trace run-time done");
    probe_u.scan(1'b1, {27'h0, DTP_IR_RTM}, 5);
    chk(realtime_mode, 1'b1);
    chk(stat_out, 32'h2);
    probe_u.scan(1'b0, 32'h0, 32);
    chk(scan_data, v2);
    burst(1'b1);
    $display("test trace real-time done");
    probe_u.irq();
    chk({realtime_mode, stat_out}, 32'h0);
    probe_u.scan(1'b1, {27'h0, DTP_IR_RTM}, 5);
    probe_u.treset();
    chk({realtime_mode, stat_out}, 32'h0);
    chk(scan_data, 32'h0);
    probe_u.scan(1'b1, 32'h01, 5);
    chk(probe_u.cap_r, 32'h01);
    $display("test interrupt and test reset done");
    print_verdict();
  end
endmodule
